/* File: design/txfis_intake.sv */
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module txfis_intake import txfis_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// MAC-side data stream
	output logic mac_valid_out,
	output txfis_beat_t mac_beat_out,
	input wire logic mac_ready_in,
	output logic store_forward_enable_out,
	output logic tx_halted_out,
	// Per-packet result from the MAC engine
	input wire logic mac_status_valid_in,
	input wire txfis_mstat_t mac_status_in
);
	typedef enum logic [1:0] {
		TXFIS_S_CMDA = 2'b00,
		TXFIS_S_CMDB = 2'b01,
		TXFIS_S_DATA = 2'b10
	} txfis_state_t;

	function automatic logic [3:0] txfis_lanes(input logic [1:0] first, input logic [1:0] last);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			m[i] = (2'(i) >= first) && (2'(i) <= last);
		end
		return m;
	endfunction

	// Bus
	logic ack_r;
	logic [31:0] dat_r;
	logic req, wr_done, rd_done, data_stall;
	// Config and error
	logic store_forward_enable_r, status_discard_overrun_allow_r;
	logic transmitter_error_flag_r;
	// Intake
	txfis_state_t state_r;
	logic [31:0] cmda_r, cmdb_r;
	logic [8:0] word_idx_r, words_total_r, words_skip_r, words_data_r;
	logic [11:0] size_sum_r;
	logic first_seg_r, last_seg_r;
	// Data FIFO
	txfis_entry_t dmem [0:(1<<TXFIS_DFIFO_AW)-1];
	logic [TXFIS_DFIFO_AW:0] dwp_r, drp_r;
	logic dfull, dempty, dpush, dpop;
	txfis_entry_t din, dhead;
	// MAC side
	logic [15:0] tag_r, done_tag_r;
	logic [11:0] mac_used_r;
	logic out_load;
	// Status FIFO
	logic [31:0] smem [0:(1<<TXFIS_SFIFO_AW)-1];
	logic [TXFIS_SFIFO_AW:0] swp_r, srp_r;
	logic sfull, sempty, spush, spop, overrun_lock_r, sovr;
	logic [31:0] sword;
	logic [TXFIS_SFIFO_AW:0] status_used_count;

	// Single-cycle registered ack, data writes wait for FIFO room
	assign dfull = (dwp_r[TXFIS_DFIFO_AW] != drp_r[TXFIS_DFIFO_AW]) &&
		(dwp_r[TXFIS_DFIFO_AW-1:0] == drp_r[TXFIS_DFIFO_AW-1:0]);
	assign dempty = (dwp_r == drp_r);
	assign data_stall = wb_we_in && (wb_adr_in == TXFIS_ADR_DATA) && dfull;
	assign req = wb_cyc_in && wb_stb_in;
	assign wr_done = req && ack_r && wb_we_in;
	assign rd_done = req && ack_r && !wb_we_in;
	assign wb_ack_out = ack_r;
	assign wb_dat_out = dat_r;

	always_ff @(posedge mclk_in) begin
		if (reset_in)
			ack_r <= 1'b0;
		else
			ack_r <= req && !ack_r && !data_stall;
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			dat_r <= 32'h0;
		end else if (req && !ack_r && !wb_we_in) begin
			unique case (wb_adr_in)
				TXFIS_ADR_STATUS: dat_r <= sempty ? 32'h0 : smem[srp_r[TXFIS_SFIFO_AW-1:0]];
				TXFIS_ADR_CONFIG: dat_r <= {30'h0, status_discard_overrun_allow_r,
					store_forward_enable_r};
				TXFIS_ADR_INFO: dat_r <= {11'h0, status_used_count, 10'h0,
					dwp_r - drp_r};
				TXFIS_ADR_ERROR: dat_r <= {31'h0, transmitter_error_flag_r};
				TXFIS_ADR_MACUSED: dat_r <= {20'h0, mac_used_r};
				default: dat_r <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			store_forward_enable_r <= 1'b0;
			status_discard_overrun_allow_r <= 1'b0;
		end else if (wr_done && wb_adr_in == TXFIS_ADR_CONFIG && wb_sel_in[0]) begin
			store_forward_enable_r <= wb_dat_in[TXFIS_CFG_SF];
			status_discard_overrun_allow_r <= wb_dat_in[TXFIS_CFG_SAO];
		end
	end
	assign store_forward_enable_out = store_forward_enable_r;

	// Intake: word counts derived from command A
	logic [31:0] wa;
	logic [1:0] sub_off;
	logic [12:0] span, span_al;
	assign wa = wb_dat_in;
	assign sub_off = cmda_r[TXFIS_A_OFF_LO +: 2];

	always_comb begin
		span = 13'(wa[TXFIS_A_OFF_LO +: 5]) + 13'(wa[10:0]);
		unique case (wa[TXFIS_A_ALIGN_LO +: 2])
			TXFIS_ALIGN_16: span_al = (span + 13'hF) & ~13'hF;
			TXFIS_ALIGN_32: span_al = (span + 13'h1F) & ~13'h1F;
			default: span_al = (span + 13'h3) & ~13'h3;
		endcase
	end

	logic push_data_word, keep_word, data_wr;
	logic [8:0] rel_idx;
	logic [1:0] end_lane;
	assign data_wr = wr_done && wb_adr_in == TXFIS_ADR_DATA;
	assign rel_idx = word_idx_r - words_skip_r;
	assign keep_word = (word_idx_r >= words_skip_r) &&
		(word_idx_r < words_skip_r + words_data_r);
	assign end_lane = 2'(13'(sub_off) + 13'(cmda_r[10:0]) - 13'h1);

	always_comb begin
		dpush = 1'b0;
		din = '0;
		push_data_word = 1'b0;
		if (data_wr) begin
			unique case (state_r)
				TXFIS_S_CMDA: begin
					dpush = 1'b1;
					din.kind = TXFIS_K_CMDA;
					din.word = wa;
				end
				TXFIS_S_CMDB: begin
					dpush = first_seg_r;
					din.kind = TXFIS_K_CMDB;
					din.word = wa;
				end
				TXFIS_S_DATA: begin
					push_data_word = keep_word;
					dpush = keep_word;
					din.kind = TXFIS_K_DATA;
					din.word = wa;
					din.lanes = txfis_lanes((rel_idx == 9'h0) ? sub_off : 2'h0,
						(rel_idx == words_data_r - 9'h1) ? end_lane : 2'h3);
					din.last = last_seg_r && (rel_idx == words_data_r - 9'h1);
				end
				default: dpush = 1'b0;
			endcase
		end
	end

	logic pkt_err;
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state_r <= TXFIS_S_CMDA;
			cmda_r <= 32'h0;
			cmdb_r <= 32'h0;
			word_idx_r <= 9'h0;
			words_total_r <= 9'h0;
			words_skip_r <= 9'h0;
			words_data_r <= 9'h0;
			size_sum_r <= 12'h0;
			first_seg_r <= 1'b0;
			last_seg_r <= 1'b0;
		end else if (data_wr) begin
			unique case (state_r)
				TXFIS_S_CMDA: begin
					cmda_r <= wa;
					first_seg_r <= wa[TXFIS_A_FS];
					last_seg_r <= wa[TXFIS_A_LS];
					words_total_r <= 9'(span_al >> 2);
					words_skip_r <= 9'(wa[TXFIS_A_OFF_LO + 2 +: 3]);
					words_data_r <= 9'((13'(wa[TXFIS_A_OFF_LO +: 2]) + 13'(wa[10:0]) +
						13'h3) >> 2);
					size_sum_r <= (wa[TXFIS_A_FS] ? 12'h0 : size_sum_r) + 12'(wa[10:0]);
					state_r <= TXFIS_S_CMDB;
				end
				TXFIS_S_CMDB: begin
					if (first_seg_r)
						cmdb_r <= wa;
					word_idx_r <= 9'h0;
					state_r <= (words_total_r == 9'h0) ? TXFIS_S_CMDA : TXFIS_S_DATA;
				end
				TXFIS_S_DATA: begin
					word_idx_r <= word_idx_r + 9'h1;
					if (word_idx_r == words_total_r - 9'h1)
						state_r <= TXFIS_S_CMDA;
				end
				default: state_r <= TXFIS_S_CMDA;
			endcase
		end
	end

	// Packet consistency: B must repeat, sizes must sum to length
	assign pkt_err = data_wr && state_r == TXFIS_S_CMDB &&
		((!first_seg_r && wa != cmdb_r) ||
		(last_seg_r && size_sum_r != {1'b0, wa[10:0]}));

	// Data FIFO
	always_ff @(posedge mclk_in) begin
		if (dpush)
			dmem[dwp_r[TXFIS_DFIFO_AW-1:0]] <= din;
	end
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			dwp_r <= '0;
			drp_r <= '0;
		end else begin
			if (dpush)
				dwp_r <= dwp_r + 1'b1;
			if (dpop)
				drp_r <= drp_r + 1'b1;
		end
	end
	assign dhead = dmem[drp_r[TXFIS_DFIFO_AW-1:0]];

	// MAC side: commands dropped here, data held while status is blocked
	assign tx_halted_out = sfull && !status_discard_overrun_allow_r;
	assign out_load = !dempty && dhead.kind == TXFIS_K_DATA &&
		(!mac_valid_out || mac_ready_in) && !tx_halted_out;
	assign dpop = (!dempty && dhead.kind != TXFIS_K_DATA) || out_load;

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			mac_valid_out <= 1'b0;
			mac_beat_out <= '0;
		end else if (out_load) begin
			mac_valid_out <= 1'b1;
			mac_beat_out <= '{data: dhead.word, lanes: dhead.lanes, last: dhead.last,
				tag: tag_r};
		end else if (mac_ready_in) begin
			mac_valid_out <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			tag_r <= 16'h0;
			mac_used_r <= 12'h0;
		end else if (!dempty && dhead.kind == TXFIS_K_CMDB) begin
			tag_r <= dhead.word[31:16];
		end else if (!dempty && dhead.kind == TXFIS_K_CMDA && dhead.word[TXFIS_A_FS]) begin
			mac_used_r <= 12'h0;
		end else if (out_load) begin
			mac_used_r <= mac_used_r + 12'h4;
		end
	end

	// Tag of the packet the MAC has finished taking
	always_ff @(posedge mclk_in) begin
		if (reset_in)
			done_tag_r <= 16'h0;
		else if (mac_valid_out && mac_ready_in && mac_beat_out.last)
			done_tag_r <= mac_beat_out.tag;
	end

	// Status word assembly
	always_comb begin
		sword = 32'h0;
		sword[31:16] = done_tag_r;
		sword[11] = mac_status_in.lost_carrier;
		sword[10] = mac_status_in.no_carrier;
		sword[9] = mac_status_in.late_collision;
		sword[8] = mac_status_in.excess_collisions;
		sword[6:3] = mac_status_in.collision_count;
		sword[2] = mac_status_in.excess_deferral;
		sword[1] = mac_status_in.underrun;
		sword[0] = mac_status_in.deferred;
		sword[15] = |{sword[11:8], sword[2:1]};
	end

	// Status FIFO
	assign sfull = (swp_r[TXFIS_SFIFO_AW] != srp_r[TXFIS_SFIFO_AW]) &&
		(swp_r[TXFIS_SFIFO_AW-1:0] == srp_r[TXFIS_SFIFO_AW-1:0]);
	assign sempty = (swp_r == srp_r);
	assign spush = mac_status_valid_in && !sfull && !overrun_lock_r;
	assign sovr = mac_status_valid_in && sfull;
	// Pop only what was handed out; a push between take and ack must survive
	logic st_pop_ok_r;
	always_ff @(posedge mclk_in) begin
		if (reset_in)
			st_pop_ok_r <= 1'b0;
		else if (req && !ack_r && !wb_we_in)
			st_pop_ok_r <= (wb_adr_in == TXFIS_ADR_STATUS) && !sempty;
	end
	assign spop = rd_done && wb_adr_in == TXFIS_ADR_STATUS && st_pop_ok_r;
	assign status_used_count = overrun_lock_r ? '0 : (swp_r - srp_r);

	always_ff @(posedge mclk_in) begin
		if (spush)
			smem[swp_r[TXFIS_SFIFO_AW-1:0]] <= sword;
	end
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			swp_r <= '0;
			srp_r <= '0;
		end else begin
			if (spush)
				swp_r <= swp_r + 1'b1;
			if (spop)
				srp_r <= srp_r + 1'b1;
		end
	end

	// Lock lifts on a host read; a fresh overrun in that cycle keeps it
	always_ff @(posedge mclk_in) begin
		if (reset_in)
			overrun_lock_r <= 1'b0;
		else if (sovr && status_discard_overrun_allow_r)
			overrun_lock_r <= 1'b1;
		else if (spop)
			overrun_lock_r <= 1'b0;
	end

	// Sticky error, set wins over write-one-to-clear
	logic err_set;
	assign err_set = pkt_err ||
		(sovr && !status_discard_overrun_allow_r) ||
		(mac_status_valid_in && mac_status_in.underrun);
	always_ff @(posedge mclk_in) begin
		if (reset_in)
			transmitter_error_flag_r <= 1'b0;
		else if (err_set)
			transmitter_error_flag_r <= 1'b1;
		else if (wr_done && wb_adr_in == TXFIS_ADR_ERROR && wb_sel_in[0] && wb_dat_in[0])
			transmitter_error_flag_r <= 1'b0;
	end
endmodule
`default_nettype wire

/* File: design/txfis_pkg.sv */
package txfis_pkg;
	// Register byte addresses
	localparam logic [7:0] TXFIS_ADR_DATA = 8'h00;
	localparam logic [7:0] TXFIS_ADR_STATUS = 8'h04;
	localparam logic [7:0] TXFIS_ADR_CONFIG = 8'h08;
	localparam logic [7:0] TXFIS_ADR_INFO = 8'h0C;
	localparam logic [7:0] TXFIS_ADR_ERROR = 8'h10;
	localparam logic [7:0] TXFIS_ADR_MACUSED = 8'h14;
	// Config bits
	localparam int TXFIS_CFG_SF = 0;
	localparam int TXFIS_CFG_SAO = 1;
	// Command word A fields
	localparam int TXFIS_A_ALIGN_LO = 24;
	localparam int TXFIS_A_OFF_LO = 16;
	localparam int TXFIS_A_FS = 13;
	localparam int TXFIS_A_LS = 12;
	// Alignment selector codes
	localparam logic [1:0] TXFIS_ALIGN_16 = 2'h1;
	localparam logic [1:0] TXFIS_ALIGN_32 = 2'h2;
	// Depths
	localparam int TXFIS_DFIFO_AW = 5;
	localparam int TXFIS_SFIFO_AW = 4;
	localparam int TXFIS_INFO_SUSED_LO = 16;
	typedef enum logic [1:0] {
		TXFIS_K_CMDA = 2'b00,
		TXFIS_K_CMDB = 2'b01,
		TXFIS_K_DATA = 2'b10
	} txfis_kind_t;
	typedef struct packed {
		txfis_kind_t kind;
		logic [31:0] word;
		logic [3:0] lanes;
		logic last;
	} txfis_entry_t;
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] lanes;
		logic last;
		logic [15:0] tag;
	} txfis_beat_t;
	typedef struct packed {
		logic lost_carrier;
		logic no_carrier;
		logic late_collision;
		logic excess_collisions;
		logic [3:0] collision_count;
		logic excess_deferral;
		logic underrun;
		logic deferred;
	} txfis_mstat_t;
endpackage

/* File: testbench/tb_tx_fifo_intake_and_status.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_tx_fifo_intake_and_status;
	import txfis_pkg::*;
	logic mclk_in = 0, reset_in = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, stall = 0;
	logic [7:0] wb_adr_in = 0;
	logic [3:0] wb_sel_in = 4'hF;
	logic [31:0] wb_dat_in = 0, wb_dat_out, rd;
	logic wb_ack_out, mac_valid_out, mac_ready_in, store_forward_enable_out, tx_halted_out;
	logic mac_status_valid_in;
	txfis_beat_t mac_beat_out;
	txfis_beat_t exp_q[$];
	txfis_mstat_t mac_status_in, stat = '0;
	int seed = 32'h7604a3de;
	int num_errors = 0, num_checks = 0;
	txfis_intake dut_u (.mclk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
		.wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .mac_valid_out, .mac_beat_out,
		.mac_ready_in, .store_forward_enable_out, .tx_halted_out, .mac_status_valid_in,
		.mac_status_in);
	txfis_mac_model mac_u (.mclk_in, .reset_in, .stall_in(stall), .stat_in(stat),
		.mac_valid_in(mac_valid_out), .mac_beat_in(mac_beat_out), .mac_ready_out(mac_ready_in),
		.status_valid_out(mac_status_valid_in), .status_out(mac_status_in));
	always #25 mclk_in = ~mclk_in;
	always @(posedge mclk_in) stall <= ($random(seed) & 3) == 0;
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	// Expected beats queued before the word is written, so the monitor never races ahead
	task buf_send(input int off, sz, al, fs, ls, input logic [15:0] tag, input int len);
		int ab, nw, i, b;
		txfis_beat_t e;
		ab = (al == 1) ? 16 : (al == 2) ? 32 : 4;
		nw = (off + sz + ab - 1) / ab * ab / 4;
		wb(1, TXFIS_ADR_DATA, {6'h0, al[1:0], 3'h0, off[4:0], 2'h0, fs[0], ls[0], 1'h0, sz[10:0]});
		wb(1, TXFIS_ADR_DATA, {tag, 5'h0, len[10:0]});
		for (i = 0; i < nw; i++) begin
			e.data = $random(seed);
			e.tag = tag;
			e.last = ls && (i == (off + sz - 1) / 4);
			for (b = 0; b < 4; b++) e.lanes[b] = (4 * i + b >= off) && (4 * i + b < off + sz);
			if (e.lanes != 4'h0) exp_q.push_back(e);
			wb(1, TXFIS_ADR_DATA, e.data);
		end
	endtask
	task settle;
		repeat (3000) if (exp_q.size() != 0) @(posedge mclk_in);
		repeat (6) @(posedge mclk_in);
	endtask
	function logic [31:0] sw(input logic [15:0] t, input txfis_mstat_t s);
		return {t, |{s[10:7], s[2:1]}, 3'h0, s[10:7], 1'b0, s[6:0]};
	endfunction
	always @(posedge mclk_in) if (mac_valid_out === 1'b1 && mac_ready_in === 1'b1) begin
		if (exp_q.size() == 0) chk(0, "unexpected beat");
		else chk(mac_beat_out === exp_q.pop_front(), "beat mismatch");
	end
	initial begin
		repeat (60000) @(posedge mclk_in);
		num_errors++;
		test_done;
	end
	initial begin
		int i, k, a, o;
		int sz[3];
		logic [15:0] tg;
		repeat (2) @(posedge mclk_in);
		reset_in <= 1'b0;
		wb(0, TXFIS_ADR_STATUS, 0);
		chk(rd === 32'h0, "status not empty");
		wb(1, TXFIS_ADR_CONFIG, 1);
		for (i = 0; i < 16; i++) buf_send(0, 1, 0, 1, 1, 16'h100 + i[15:0], 1);
		settle;
		chk(store_forward_enable_out === 1'b1, "sf off");
		chk(tx_halted_out === 1'b1, "not halted");
		wb(0, TXFIS_ADR_INFO, 0);
		chk(rd[20:16] === 5'h10, "used count");
		for (i = 0; i < 16; i++) begin
			wb(0, TXFIS_ADR_STATUS, 0);
			chk(rd === sw(16'h100 + i[15:0], '0), "status word");
		end
		@(posedge mclk_in);
		chk(tx_halted_out === 1'b0, "still halted");
		wb(1, TXFIS_ADR_CONFIG, 3);
		for (i = 0; i < 17; i++) buf_send(0, 1, 0, 1, 1, 16'h200 + i[15:0], 1);
		settle;
		chk(tx_halted_out === 1'b0, "halted with allow");
		wb(0, TXFIS_ADR_INFO, 0);
		chk(rd[20:16] === 5'h0, "used after overrun");
		wb(0, TXFIS_ADR_ERROR, 0);
		chk(rd[0] === 1'b0, "error on allowed overrun");
		for (i = 0; i < 16; i++) begin
			wb(0, TXFIS_ADR_STATUS, 0);
			chk(rd === sw(16'h200 + i[15:0], '0), "kept status");
		end
		wb(1, TXFIS_ADR_CONFIG, 1);
		for (k = 0; k < 12; k++) begin
			tg = 16'($random(seed));
			stat <= txfis_mstat_t'(11'($random(seed)) & 11'h7FD);
			for (i = 0; i < 3; i++) sz[i] = (i == 1) ? 4 + ($random(seed) & 15) : 1 + ($random(seed) & 31);
			for (i = 0; i < 3; i++) begin
				o = $random(seed) & 31;
				a = $random(seed) & 3;
				buf_send(o, sz[i], a, i == 0, i == 2, tg, sz[0] + sz[1] + sz[2]);
			end
			settle;
			wb(0, TXFIS_ADR_STATUS, 0);
			chk(rd === sw(tg, stat), "random status");
		end
		wb(0, TXFIS_ADR_ERROR, 0);
		chk(rd[0] === 1'b0, "spurious error");
		buf_send(0, 5, 0, 1, 1, 16'h77, 6);
		settle;
		wb(0, TXFIS_ADR_ERROR, 0);
		chk(rd[0] === 1'b1, "length mismatch unflagged");
		wb(0, TXFIS_ADR_MACUSED, 0);
		chk(rd[11:0] === 12'h8, "mac space");
		wb(1, TXFIS_ADR_ERROR, 1);
		wb(0, TXFIS_ADR_STATUS, 0);
		stat <= 11'h002;
		buf_send(1, 3, 0, 1, 1, 16'h55, 3);
		settle;
		wb(0, TXFIS_ADR_STATUS, 0);
		chk(rd === sw(16'h55, 11'h002), "underrun status");
		wb(0, TXFIS_ADR_ERROR, 0);
		chk(rd[0] === 1'b1, "underrun unflagged");
		test_done;
	end
endmodule
`default_nettype wire

/* File: testbench/txfis_intake_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module txfis_intake_chk import txfis_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// Stream and status
	input wire logic mac_valid_out,
	input wire txfis_beat_t mac_beat_out,
	input wire logic mac_ready_in,
	input wire logic store_forward_enable_out,
	input wire logic tx_halted_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	wire logic rd_st = wb_ack_out && !wb_we_in && wb_adr_in == TXFIS_ADR_STATUS;
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	ack_soon_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out &&
		!(wb_we_in && wb_adr_in == TXFIS_ADR_DATA) |=> wb_ack_out) else $error("no ack");
	beat_hold_a: assert property (mac_valid_out && !mac_ready_in |=>
		mac_valid_out && $stable(mac_beat_out)) else $error("beat dropped");
	lanes_live_a: assert property (mac_valid_out |-> mac_beat_out.lanes != 4'h0)
		else $error("empty beat");
	halt_stop_a: assert property ($rose(mac_valid_out) |-> !$past(tx_halted_out))
		else $error("beat while halted");
	es_sum_a: assert property (rd_st |->
		wb_dat_out[15] == |{wb_dat_out[11:8], wb_dat_out[2:1]}) else $error("bad summary");
	resv_zero_a: assert property (rd_st |-> wb_dat_out[14:12] == 3'h0 && !wb_dat_out[7])
		else $error("reserved bits set");
	sf_write_a: assert property ($changed(store_forward_enable_out) |->
		$past(wb_ack_out && wb_we_in && wb_adr_in == TXFIS_ADR_CONFIG)) else $error("sf moved");
	cover property (mac_valid_out && mac_ready_in && mac_beat_out.last);
	cover property (tx_halted_out);
	cover property (rd_st && wb_dat_out[15]);
endmodule
bind txfis_intake txfis_intake_chk chk_u (.mclk_in, .reset_in, .wb_cyc_in, .wb_stb_in,
	.wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .mac_valid_out, .mac_beat_out,
	.mac_ready_in, .store_forward_enable_out, .tx_halted_out);
`default_nettype wire

/* File: testbench/txfis_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module txfis_mac_model import txfis_pkg::*; (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Control from bench
	input wire logic stall_in,
	input wire txfis_mstat_t stat_in,
	// Stream
	input wire logic mac_valid_in,
	input wire txfis_beat_t mac_beat_in,
	output logic mac_ready_out,
	// Result
	output logic status_valid_out,
	output txfis_mstat_t status_out
);
	always_ff @(posedge mclk_in) begin
		mac_ready_out <= !reset_in && !stall_in;
		// One result per packet, after its final word is taken
		status_valid_out <= !reset_in && mac_valid_in && mac_ready_out && mac_beat_in.last;
		status_out <= stat_in;
	end
endmodule
`default_nettype wire
